// file: rtl/agc_avg.v
// block mean of channel filter amplitude over a programmable window
`timescale 1ns/100ps
`default_nettype none
module agc_avg #(
  parameter AW = 8
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          rst_n,
  // sample stream
  input  wire          smp_en,
  input  wire          clr,
  input  wire [AW-1:0] smp,
  input  wire [1:0]    len_sel,
  // result
  output reg  [AW-1:0] avg_q,
  output reg           avg_vld_q
);
  reg [AW+5:0] sum_q;
  reg [6:0]    cnt_q;
  wire [6:0]   len = 7'h08 << len_sel;
  wire [AW+5:0] sum_n = sum_q + {6'h00, smp};
  // window length is a power of two, so the mean is a shift
  wire [AW+5:0] mean  = sum_n >> (3 + len_sel);

  // accumulate, emit mean at window end
  always @(posedge ref_clk)
  begin
    avg_vld_q <= 1'b0;
    if (!rst_n || clr)
    begin
      sum_q <= {(AW+6){1'b0}};
      cnt_q <= 7'h00;
      if (!rst_n)
        avg_q <= {AW{1'b0}};
    end
    else if (smp_en)
    begin
      if (cnt_q + 7'h01 >= len)
      begin
        avg_q     <= mean[AW-1:0];
        avg_vld_q <= 1'b1;
        sum_q     <= {(AW+6){1'b0}};
        cnt_q     <= 7'h00;
      end
      else
      begin
        sum_q <= sum_n;
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end
endmodule // agc_avg
`default_nettype wire

// file: rtl/agc_defs.vh
// constants for the gain loop control block
`ifndef AGC_DEFS_VH
`define AGC_DEFS_VH
`define AGC_GLC1_ADDR      6'h1c
`define AGC_GLC1_RESET     8'h91
`define AGC_HYST_MSB       7
`define AGC_HYST_LSB       6
`define AGC_WAIT_MSB       5
`define AGC_WAIT_LSB       4
`define AGC_HOLD_MSB       3
`define AGC_HOLD_LSB       2
`define AGC_FLEN_MSB       1
`define AGC_FLEN_LSB       0
`define AGC_HOLD_NORMAL    2'h0
`define AGC_HOLD_ON_SYNC   2'h1
`define AGC_HOLD_ANALOGUE  2'h2
`define AGC_HOLD_ALL       2'h3
`define AGC_WAIT_STEP      6'h08
`define AGC_BOUND_STEP_DB  5'h04
`define AGC_DEAD_ZONE_BASE 8'h02
`endif

// file: rtl/agc_gain_loop.v
// gain loop controller with its control register
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "agc_defs.vh"
module agc_gain_loop #(
  parameter AW = 8,
  parameter GW = 4
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          rst_n,
  // register port
  input  wire [5:0]    reg_addr,
  input  wire          reg_wr,
  input  wire [7:0]    reg_wdata,
  output reg  [7:0]    reg_rdata,
  // receive datapath
  input  wire          smp_en,
  input  wire [AW-1:0] smp_amp,
  input  wire [AW-1:0] magn_target,
  input  wire          ask_mode,
  input  wire          sync_found,
  input  wire          rx_start,
  input  wire [GW-1:0] man_ana_gain,
  input  wire [GW-1:0] man_dig_gain,
  // gain, slicer and settling outputs
  output reg  [GW-1:0] ana_gain_q,
  output reg  [GW-1:0] dig_gain_q,
  output reg  [4:0]    ask_bound_db_q,
  output reg           settling_q
);
  // ---------------------------------------------------------------
  // register
  // ---------------------------------------------------------------
  reg  [7:0] gain_loop_control_one_q;
  wire [1:0] deviation_hysteresis_sel = gain_loop_control_one_q[`AGC_HYST_MSB:`AGC_HYST_LSB];
  wire [1:0] wait_sel                 = gain_loop_control_one_q[`AGC_WAIT_MSB:`AGC_WAIT_LSB];
  wire [1:0] gain_hold_policy         = gain_loop_control_one_q[`AGC_HOLD_MSB:`AGC_HOLD_LSB];
  wire [1:0] flen_sel                 = gain_loop_control_one_q[`AGC_FLEN_MSB:`AGC_FLEN_LSB];

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      gain_loop_control_one_q <= `AGC_GLC1_RESET;
    else if (reg_wr && reg_addr == `AGC_GLC1_ADDR)
      gain_loop_control_one_q <= reg_wdata;
  end

  // readback, unmapped reads as zero
  always @*
  begin
    reg_rdata = (reg_addr == `AGC_GLC1_ADDR) ? gain_loop_control_one_q : 8'h00;
  end

  // ---------------------------------------------------------------
  // averaging and slicer boundary
  // ---------------------------------------------------------------
  wire          avg_vld;
  wire [AW-1:0] avg;
  reg  [5:0]    wait_cnt_q;
  reg           sync_seen_q;

  agc_avg #(.AW(AW)) u_avg (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .smp_en    (smp_en && !settling_q),
    .clr       (settling_q || rx_start),
    .smp       (smp_amp),
    .len_sel   (flen_sel),
    .avg_q     (avg),
    .avg_vld_q (avg_vld)
  );

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      ask_bound_db_q <= 5'h00;
    else
      ask_bound_db_q <= `AGC_BOUND_STEP_DB * ({3'h0, flen_sel} + 5'h01);
  end

  // ---------------------------------------------------------------
  // decision with hysteresis
  // ---------------------------------------------------------------
  // dead zone sizing; upper side grows faster, giving higher gain
  wire [AW:0] dz_lo = {1'b0, `AGC_DEAD_ZONE_BASE} + ({{(AW-1){1'b0}}, deviation_hysteresis_sel} << 1);
  wire [AW:0] dz_hi = {1'b0, `AGC_DEAD_ZONE_BASE} + ({{(AW-1){1'b0}}, deviation_hysteresis_sel} << 2);
  wire [AW:0] amp_x = {1'b0, avg};
  wire [AW:0] tgt_x = {1'b0, magn_target};
  wire too_big   = amp_x > tgt_x + dz_hi;
  wire too_small = amp_x + dz_lo < tgt_x;

  // sync freeze latch, cleared at start of reception
  always @(posedge ref_clk)
  begin
    if (!rst_n || rx_start)
      sync_seen_q <= 1'b0;
    else if (sync_found)
      sync_seen_q <= 1'b1;
  end

  wire hold_ana = (gain_hold_policy == `AGC_HOLD_ANALOGUE) || (gain_hold_policy == `AGC_HOLD_ALL)
                  || (gain_hold_policy == `AGC_HOLD_ON_SYNC && sync_seen_q);
  wire hold_dig = (gain_hold_policy == `AGC_HOLD_ALL)
                  || (gain_hold_policy == `AGC_HOLD_ON_SYNC && sync_seen_q);
  wire eval     = avg_vld && !settling_q;
  wire ana_dn   = eval && too_big   && !hold_ana && ana_gain_q != {GW{1'b0}};
  wire ana_up   = eval && too_small && !hold_ana && ana_gain_q != {GW{1'b1}};
  wire dig_dn   = eval && too_big   && !hold_dig && !ana_dn && dig_gain_q != {GW{1'b0}};
  wire dig_up   = eval && too_small && !hold_dig && !ana_up && dig_gain_q != {GW{1'b1}};
  wire changed  = ana_dn || ana_up || dig_dn || dig_up;

  // gain steps: normal, analogue held, manual override
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ana_gain_q <= {GW{1'b1}};
      dig_gain_q <= {GW{1'b1}};
    end
    else if (gain_hold_policy == `AGC_HOLD_ALL)
    begin
      ana_gain_q <= man_ana_gain;
      dig_gain_q <= man_dig_gain;
    end
    else
    begin
      if (ana_dn)
        ana_gain_q <= ana_gain_q - {{(GW-1){1'b0}}, 1'b1};
      else if (ana_up)
        ana_gain_q <= ana_gain_q + {{(GW-1){1'b0}}, 1'b1};
      if (dig_dn)
        dig_gain_q <= dig_gain_q - {{(GW-1){1'b0}}, 1'b1};
      else if (dig_up)
        dig_gain_q <= dig_gain_q + {{(GW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      settling_q <= 1'b0;
      wait_cnt_q <= 6'h00;
    end
    else if (changed)
    begin
      settling_q <= 1'b1;
      wait_cnt_q <= `AGC_WAIT_STEP * ({4'h0, wait_sel} + 6'h01);
    end
    else if (settling_q && smp_en)
    begin
      wait_cnt_q <= wait_cnt_q - 6'h01;
      if (wait_cnt_q == 6'h01)
        settling_q <= 1'b0;
    end
  end
endmodule // agc_gain_loop
`default_nettype wire

// file: verif/agc_gain_control_config_test.sv
// self-checking bench for the gain loop block
`timescale 1ns/100ps
`default_nettype none
module agc_gain_control_config_test;
  logic       ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, smp_en = 1'b0, ask_mode = 1'b0;
  logic       sync_found = 1'b0, rx_start = 1'b0, settling_q;
  logic [5:0] reg_addr = 6'h1c;
  logic [7:0] reg_wdata = 8'h00, smp_amp = 8'hf0, magn_target = 8'h20, reg_rdata;
  logic [3:0] man_ana_gain = 4'h5, man_dig_gain = 4'ha, ana_gain_q, dig_gain_q;
  logic [4:0] ask_bound_db_q;
  int         error_cnt = 0, checked = 0, cyc = 0, n;
  agc_gain_loop uut (.*);
  // 100 ns clock, and a hang guard well past the longest run
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 20000) end_sim(1);
  task automatic end_sim(input int e);
    if (error_cnt + e == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    error_cnt += int'(got !== exp);
    if (got !== exp) $display("ERROR %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk) reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk) reg_wr <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic pulse(input int k);
    repeat (k)
    begin
      @(posedge ref_clk) smp_en <= 1'b1;
      @(posedge ref_clk) smp_en <= 1'b0;
      @(posedge ref_clk);
    end
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic restart(input logic s);
    @(posedge ref_clk) rx_start <= 1'b1;
    @(posedge ref_clk) rx_start <= 1'b0;
    sync_found <= s;
    @(posedge ref_clk) sync_found <= 1'b0;
  endtask
  task automatic t_reg();
    chk(reg_rdata, 8'h91);
    wr(6'h05, 8'h3c);
    chk(reg_rdata, 8'h00);
    for (int f = 0; f < 4; f++)
    begin
      wr(6'h1c, 8'(f));
      @(negedge ref_clk);
      chk({3'h0, ask_bound_db_q}, 8'(4 * f + 4));
    end
  endtask
  task automatic t_settle();
    for (int w = 0; w < 4; w++)
    begin
      wr(6'h1c, 8'(w << 4));
      restart(1'b0);
      pulse(7);
      chk({7'h0, settling_q}, 8'h00);
      pulse(1);
      for (n = 0; settling_q === 1'b1 && n < 40; n++)
        pulse(1);
      chk(n[7:0], 8'(8 * w + 8));
    end
  endtask
  task automatic t_hold();
    wr(6'h1c, 8'h08);
    pulse(20);
    chk({4'h0, dig_gain_q}, 8'h0e);
    chk({4'h0, ana_gain_q}, 8'h0b);
    wr(6'h1c, 8'h0c);
    @(negedge ref_clk);
    chk({ana_gain_q, dig_gain_q}, 8'h5a);
    wr(6'h1c, 8'h04);
    restart(1'b1);
    pulse(20);
    chk({ana_gain_q, dig_gain_q}, 8'h5a);
    restart(1'b0);
    pulse(20);
    chk({7'h0, {ana_gain_q, dig_gain_q} !== 8'h5a}, 8'h01);
  endtask
  // amplitude 12 above target: inside the widest dead zone, outside the narrowest
  task automatic t_hyst();
    logic [7:0] g;
    smp_amp <= 8'h2c;
    wr(6'h1c, 8'hc0);
    restart(1'b0);
    g = {ana_gain_q, dig_gain_q};
    pulse(10);
    chk({ana_gain_q, dig_gain_q}, g);
    wr(6'h1c, 8'h00);
    restart(1'b0);
    pulse(10);
    chk({7'h0, settling_q}, 8'h01);
  endtask
  // reset for twelve cycles, then the scenarios
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reg();
    t_settle();
    t_hold();
    t_hyst();
    end_sim(0);
  end
endmodule // agc_gain_control_config_test
bind agc_gain_loop agc_gain_loop_props #(.GW(GW)) u_props (.*);
`default_nettype wire

// file: verif/agc_gain_loop_props.sv
// port-level assertions for the gain loop block
`timescale 1ns/100ps
`default_nettype none
module agc_gain_loop_props #(parameter GW = 4) (
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire logic [5:0]    reg_addr,
  input wire logic          reg_wr,
  input wire logic [7:0]    reg_wdata,
  input wire logic [7:0]    reg_rdata,
  input wire logic          sync_found,
  input wire logic          rx_start,
  input wire logic [GW-1:0] man_ana_gain,
  input wire logic [GW-1:0] ana_gain_q,
  input wire logic [GW-1:0] dig_gain_q,
  input wire logic [4:0]    ask_bound_db_q,
  input wire logic          settling_q
);
  // hold code seen live through readback; top bit says the readback is valid
  wire logic [2:0] pol = {reg_addr == 6'h1c, reg_rdata[3:2]};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence sync_hit; pol == 3'h5 && sync_found && !rx_start ##1 pol == 3'h5 && !rx_start; endsequence
  AST_RD0: assert property (!pol[2] |-> reg_rdata == 8'h00) else $error("stray read");
  AST_RDB: assert property (reg_wr && pol[2] ##1 pol[2] |-> reg_rdata == $past(reg_wdata)) else $error("lost");
  AST_MAN: assert property (pol == 3'h7 |=> ana_gain_q == $past(man_ana_gain)) else $error("manual");
  AST_ANA: assert property (pol == 3'h6 |=> $stable(ana_gain_q)) else $error("analogue moved");
  AST_SYN: assert property (sync_hit |=> $stable({ana_gain_q, dig_gain_q})) else $error("sync freeze");
  AST_BND: assert property (pol[2] |=> ask_bound_db_q == {$past(reg_rdata[1:0]) + 3'h1, 2'h0}) else $error("bound");
  AST_SET: assert property ($rose(settling_q) |-> settling_q[*8]) else $error("short wait");
  AST_STP: assert property ($changed({ana_gain_q, dig_gain_q}) && $past(pol) == 3'h4 |-> $rose(settling_q)) else $error("step");
endmodule // agc_gain_loop_props
`default_nettype wire
